// [verilog/hslc_regs.vh]
// Register map, field positions and reset values of the strap/LED block
`ifndef HSLC_REGS_VH
`define HSLC_REGS_VH

// ============================================================
// Register byte offsets
`define HSLC_CTRL_ADDR     12'h000
`define HSLC_LED_ADDR      12'h004
`define HSLC_PWR_ADDR      12'h008
`define HSLC_STAT_ADDR     12'h00C

// ============================================================
// Control register fields
`define HSLC_CTRL_EXT_BIT  0
`define HSLC_CTRL_LEDEN_BIT 1
`define HSLC_CTRL_MASK     32'h0000_0003
`define HSLC_CTRL_RESET    32'h0000_0000

// ============================================================
// LED register fields: green on [3:0], amber on [7:4], port 1 = bit 0
`define HSLC_LED_GREEN_LSB 0
`define HSLC_LED_AMBER_LSB 4
`define HSLC_LED_MASK      32'h0000_00FF
`define HSLC_LED_RESET     32'h0000_0000

// ============================================================
// Port power request register: [3:0], port 1 = bit 0
`define HSLC_PWR_MASK      32'h0000_000F
`define HSLC_PWR_RESET     32'h0000_0000

// ============================================================
// Status register fields (read only)
`define HSLC_STAT_FIXED_LSB 0
`define HSLC_STAT_DIS_LSB   2
`define HSLC_STAT_LEDSUP_BIT 4
`define HSLC_STAT_MTT_BIT   5
`define HSLC_STAT_GANG_BIT  6
`define HSLC_STAT_POL_BIT   7
`define HSLC_STAT_DONE_BIT  8
`define HSLC_STAT_EN_LSB    9
`define HSLC_STAT_NREM_LSB  13

// ============================================================
// AXI responses
`define HSLC_RESP_OKAY     2'h0
`define HSLC_RESP_SLVERR   2'h2

`endif

// [verilog/hslc_strap_led.v]
// Hub strap sampling, LED polarity and port power enable logic
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "hslc_regs.vh"

module hslc_strap_led #(
	parameter ADDR_W = 12
) (
	input  wire              sys_clk_i,
	input  wire              resetn_i,
	// AXI4-Lite slave
	input  wire [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire              s_axi_awvalid_i,
	output reg               s_axi_awready_o,
	input  wire [31:0]       s_axi_wdata_i,
	input  wire [3:0]        s_axi_wstrb_i,
	input  wire              s_axi_wvalid_i,
	output reg               s_axi_wready_o,
	output reg  [1:0]        s_axi_bresp_o,
	output reg               s_axi_bvalid_o,
	input  wire              s_axi_bready_i,
	input  wire [ADDR_W-1:0] s_axi_araddr_i,
	input  wire              s_axi_arvalid_i,
	output reg               s_axi_arready_o,
	output reg  [31:0]       s_axi_rdata_o,
	output reg  [1:0]        s_axi_rresp_o,
	output reg               s_axi_rvalid_o,
	input  wire              s_axi_rready_i,
	// Shared LED / strap pins
	input  wire [1:0]        green_led_low_ports_i,
	output reg  [1:0]        green_led_low_ports_o,
	output reg               green_led_low_ports_oe_o,
	input  wire [1:0]        green_led_high_ports_i,
	output reg  [1:0]        green_led_high_ports_o,
	output reg               green_led_high_ports_oe_o,
	input  wire              amber_led_port4_i,
	output reg               amber_led_port4_o,
	output reg               amber_led_port4_oe_o,
	output reg               amber_led_port3_o,
	output reg               amber_led_port3_oe_o,
	input  wire              amber_led_port2_i,
	output reg               amber_led_port2_o,
	output reg               amber_led_port2_oe_o,
	input  wire              amber_led_port1_i,
	output reg               amber_led_port1_o,
	output reg               amber_led_port1_oe_o,
	// Port power
	input  wire              power_polarity_strap_i,
	output reg  [3:0]        port_power_enable_o,
	// Configuration seen by the hub core
	output reg  [3:0]        port_enabled_o,
	output reg  [2:0]        non_removable_o,
	output reg               multi_tt_o,
	output reg               gang_power_o
);

	// ============================================================
	// Helper functions

	// Pin level for a logical on/off at a given active level
	function drive_lvl;
		input on;
		input act_high;
		begin
			drive_lvl = act_high ? on : ~on;
		end
	endfunction

	// Thermometer mask from a two-bit strap: 00,01,10,11 -> 0,1,2,3 ones
	function [2:0] thermo;
		input [1:0] code;
		begin
			case (code)
			2'h0: thermo = 3'h0;
			2'h1: thermo = 3'h1;
			2'h2: thermo = 3'h3;
			default: thermo = 3'h7;
			endcase
		end
	endfunction

	// Byte-lane merge of a write into an existing word
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer      k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k])
					merge[k*8 +: 8] = data[k*8 +: 8];
			end
		end
	endfunction

	// ============================================================
	// Strap synchronisers: pins are asynchronous to the core clock

	// Bit order: polarity, amber 1, amber 2, amber 4, green 4..1
	reg  [7:0]        strap_meta;
	reg  [7:0]        strap_sync;

	// Free running so a settled value is ready at reset release
	always @(posedge sys_clk_i) begin
		strap_meta <= {power_polarity_strap_i, amber_led_port1_i,
			amber_led_port2_i, amber_led_port4_i,
			green_led_high_ports_i, green_led_low_ports_i};
		strap_sync <= strap_meta;
	end

	// ============================================================
	// Strap capture at reset release

	reg  [1:0]        fixed_device_strap;
	reg  [1:0]        port_disable_strap;
	reg               led_support_strap;
	reg               multi_translator_strap;
	reg               gang_strap;
	reg               power_polarity_strap;
	reg               sampled;

	// Captured once on the first edge after release, then frozen
	always @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			sampled                <= 1'b0;
			fixed_device_strap     <= 2'h0;
			port_disable_strap     <= 2'h0;
			led_support_strap      <= 1'b0;
			multi_translator_strap <= 1'b0;
			gang_strap             <= 1'b0;
			power_polarity_strap   <= 1'b0;
		end else if (!sampled) begin
			sampled                <= 1'b1;
			fixed_device_strap     <= strap_sync[1:0];
			port_disable_strap     <= strap_sync[3:2];
			led_support_strap      <= strap_sync[4];
			multi_translator_strap <= strap_sync[5];
			gang_strap             <= strap_sync[6];
			power_polarity_strap   <= strap_sync[7];
		end
	end

	// ============================================================
	// Software registers

	reg  [31:0]       ctrl_reg;
	reg  [31:0]       led_reg;
	reg  [31:0]       pwr_reg;
	wire              ext_mode;
	wire              ext_led_gate;

	assign ext_mode     = ctrl_reg[`HSLC_CTRL_EXT_BIT];
	assign ext_led_gate = ctrl_reg[`HSLC_CTRL_LEDEN_BIT];

	// ============================================================
	// Derived configuration and pin levels

	reg  [3:0]        next_en;
	reg  [2:0]        next_nrem;
	reg  [3:0]        green_act_high;
	reg  [3:0]        amber_act_high;
	reg  [3:0]        amber_allow;
	reg               led_allow;
	reg  [3:0]        green_on;
	reg  [3:0]        amber_on;
	reg  [3:0]        pwr_on;

	// Strap meaning, except power polarity, applies only in default mode; external mode uses
	// the fixed active-low LED scheme and leaves every port usable
	always @* begin
		green_on = led_reg[`HSLC_LED_GREEN_LSB +: 4];
		amber_on = led_reg[`HSLC_LED_AMBER_LSB +: 4];
		if (ext_mode) begin
			next_en        = 4'hF;
			next_nrem      = 3'h0;
			green_act_high = 4'h0;
			amber_act_high = 4'h0;
			amber_allow    = 4'hF;
			led_allow      = ext_led_gate;
		end else begin
			next_en   = 4'hF >> port_disable_strap;
			next_nrem = thermo(fixed_device_strap);
			// Port order 4,3,2,1; a strap bit of 1 turns its green low
			green_act_high = ~{port_disable_strap, fixed_device_strap};
			// Amber 4 and 3 are active low; 2 and 1 follow their straps
			amber_act_high = {1'b0, 1'b0, ~multi_translator_strap,
				~gang_strap};
			amber_allow = {led_support_strap, 3'h7};
			led_allow   = 1'b1;
		end
		pwr_on = pwr_reg[3:0] & next_en;
	end

	// ============================================================
	// Output stage: all pins registered

	integer i;

	// Strap pins float during reset so the board straps can be read; amber 3 is driven high
	always @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			green_led_low_ports_o     <= 2'h0;
			green_led_low_ports_oe_o  <= 1'b0;
			green_led_high_ports_o    <= 2'h0;
			green_led_high_ports_oe_o <= 1'b0;
			amber_led_port4_o         <= 1'b0;
			amber_led_port4_oe_o      <= 1'b0;
			amber_led_port3_o         <= 1'b1;
			amber_led_port3_oe_o      <= 1'b1;
			amber_led_port2_o         <= 1'b0;
			amber_led_port2_oe_o      <= 1'b0;
			amber_led_port1_o         <= 1'b0;
			amber_led_port1_oe_o      <= 1'b0;
			// Inactive level from the synchronised polarity pin, not the captured strap
			port_power_enable_o       <= {4{~strap_sync[7]}};
			port_enabled_o            <= 4'h0;
			non_removable_o           <= 3'h0;
			multi_tt_o                <= 1'b0;
			gang_power_o              <= 1'b0;
		end else if (!sampled) begin
			// Straps still on the pins this cycle; keep power off
			port_power_enable_o <= {4{~strap_sync[7]}};
		end else begin
			for (i = 0; i < 2; i = i + 1) begin
				green_led_low_ports_o[i] <= drive_lvl(
					green_on[i] & led_allow, green_act_high[i]);
				green_led_high_ports_o[i] <= drive_lvl(
					green_on[i+2] & led_allow, green_act_high[i+2]);
			end
			amber_led_port4_o <= drive_lvl(amber_on[3] & led_allow
				& amber_allow[3], amber_act_high[3]);
			amber_led_port3_o <= drive_lvl(amber_on[2] & led_allow,
				amber_act_high[2]);
			amber_led_port2_o <= drive_lvl(amber_on[1] & led_allow,
				amber_act_high[1]);
			amber_led_port1_o <= drive_lvl(amber_on[0] & led_allow,
				amber_act_high[0]);
			green_led_low_ports_oe_o  <= 1'b1;
			green_led_high_ports_oe_o <= 1'b1;
			amber_led_port4_oe_o      <= 1'b1;
			amber_led_port3_oe_o      <= 1'b1;
			amber_led_port2_oe_o      <= 1'b1;
			amber_led_port1_oe_o      <= 1'b1;
			for (i = 0; i < 4; i = i + 1) begin
				port_power_enable_o[i] <= drive_lvl(pwr_on[i],
					power_polarity_strap);
			end
			port_enabled_o  <= next_en;
			non_removable_o <= next_nrem;
			multi_tt_o      <= ~ext_mode & multi_translator_strap;
			gang_power_o    <= ~ext_mode & gang_strap;
		end
	end

	// ============================================================
	// AXI4-Lite write channel

	reg  [ADDR_W-1:0] wr_addr;
	reg  [31:0]       wr_data;
	reg  [3:0]        wr_strb;

	// Address and data are taken independently; the write commits
	// once both are held, and one write is outstanding at a time
	always @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `HSLC_RESP_OKAY;
			wr_addr         <= {ADDR_W{1'b0}};
			wr_data         <= 32'h0000_0000;
			wr_strb         <= 4'h0;
			ctrl_reg        <= `HSLC_CTRL_RESET;
			led_reg         <= `HSLC_LED_RESET;
			pwr_reg         <= `HSLC_PWR_RESET;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				wr_addr         <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				wr_data        <= s_axi_wdata_i;
				wr_strb        <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (!s_axi_awready_o && !s_axi_wready_o
				&& !s_axi_bvalid_o) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= `HSLC_RESP_OKAY;
				case ({wr_addr[ADDR_W-1:2], 2'h0})
				`HSLC_CTRL_ADDR: ctrl_reg <= merge(ctrl_reg, wr_data,
					wr_strb) & `HSLC_CTRL_MASK;
				`HSLC_LED_ADDR: led_reg <= merge(led_reg, wr_data,
					wr_strb) & `HSLC_LED_MASK;
				`HSLC_PWR_ADDR: pwr_reg <= merge(pwr_reg, wr_data,
					wr_strb) & `HSLC_PWR_MASK;
				// Status is read only; unmapped space errors too
				default: s_axi_bresp_o <= `HSLC_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	// ============================================================
	// AXI4-Lite read channel

	wire [31:0]       stat_word;

	assign stat_word = {16'h0000, non_removable_o, port_enabled_o,
		sampled, power_polarity_strap, gang_strap,
		multi_translator_strap, led_support_strap,
		port_disable_strap, fixed_device_strap};

	// Read data is captured with the address, so it answers one edge
	// after the address handshake
	always @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= `HSLC_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= `HSLC_RESP_OKAY;
			case ({s_axi_araddr_i[ADDR_W-1:2], 2'h0})
			`HSLC_CTRL_ADDR: s_axi_rdata_o <= ctrl_reg;
			`HSLC_LED_ADDR:  s_axi_rdata_o <= led_reg;
			`HSLC_PWR_ADDR:  s_axi_rdata_o <= pwr_reg;
			`HSLC_STAT_ADDR: s_axi_rdata_o <= stat_word;
			default: begin
				s_axi_rdata_o <= 32'h0000_0000;
				s_axi_rresp_o <= `HSLC_RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

endmodule // hslc_strap_led

// [bench/hslc_strap_led_sva.sv]
// Concurrent checks on the strap/LED block ports
`timescale 1ns/10ps
module hslc_strap_led_sva (
	input logic       sys_clk_i,
	input logic       resetn_i,
	input logic [1:0] green_led_low_ports_i,
	input logic       green_led_low_ports_oe_o,
	input logic [1:0] green_led_high_ports_i,
	input logic       green_led_high_ports_oe_o,
	input logic       amber_led_port4_oe_o,
	input logic       amber_led_port3_oe_o,
	input logic       amber_led_port2_i,
	input logic       amber_led_port2_oe_o,
	input logic       amber_led_port1_i,
	input logic       amber_led_port1_oe_o,
	input logic       power_polarity_strap_i,
	input logic [3:0] port_power_enable_o,
	input logic [3:0] port_enabled_o,
	input logic [2:0] non_removable_o,
	input logic       multi_tt_o,
	input logic       gang_power_o
);
	logic [1:0] fx, ds;
	logic       mt, gg, pl;
	logic [2:0] cnt;
	wire        settled = (cnt == 3'h4);
	wire        all_oe = &{green_led_low_ports_oe_o, green_led_high_ports_oe_o,
		amber_led_port4_oe_o, amber_led_port3_oe_o, amber_led_port2_oe_o,
		amber_led_port1_oe_o};

	// ========================================
	// Pins show the straps while reset keeps the strap-pin LED drivers off
	always @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			fx  <= green_led_low_ports_i;
			ds  <= green_led_high_ports_i;
			mt  <= amber_led_port2_i;
			gg  <= amber_led_port1_i;
			pl  <= power_polarity_strap_i;
			cnt <= 3'h0;
		end else if (!settled) begin
			cnt <= cnt + 3'h1;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	// ========================================
	// Properties
	property p_rst_power;
		$rose(resetn_i) |-> port_power_enable_o == {4{~pl}};
	endproperty
	property p_drv_off;
		$rose(resetn_i) |-> !(green_led_low_ports_oe_o | amber_led_port1_oe_o
			| green_led_high_ports_oe_o | amber_led_port4_oe_o
			| amber_led_port2_oe_o);
	endproperty
	property p_drv_on;
		$rose(resetn_i) |-> ##3 all_oe;
	endproperty
	property p_hold_oe;
		settled |-> all_oe;
	endproperty
	property p_nrem;
		settled && non_removable_o != 3'h0 |->
			non_removable_o == 3'h7 >> (2'd3 - fx);
	endproperty
	property p_pen;
		settled && port_enabled_o != 4'hf |-> port_enabled_o == 4'hf >> ds;
	endproperty
	property p_mtt;
		settled |-> !multi_tt_o || mt;
	endproperty
	property p_gang;
		settled |-> !gang_power_o || gg;
	endproperty
	property p_off_port;
		settled |-> ((port_power_enable_o ^ {4{~pl}}) & ~port_enabled_o
			& ~$past(port_enabled_o) & ~$past(port_enabled_o, 2)) == 4'h0;
	endproperty

	a_rst_power: assert property (p_rst_power)
		else $error("power enable on at reset release");
	a_drv_off: assert property (p_drv_off)
		else $error("strap pin driven during reset");
	a_drv_on: assert property (p_drv_on)
		else $error("LED drivers not on after release");
	a_hold_oe: assert property (p_hold_oe)
		else $error("LED driver dropped after release");
	a_nrem: assert property (p_nrem)
		else $error("fixed port set differs from strap");
	a_pen: assert property (p_pen)
		else $error("enabled ports differ from strap");
	a_mtt: assert property (p_mtt)
		else $error("multi-TT on with strap low");
	a_gang: assert property (p_gang)
		else $error("ganged power with strap low");
	a_off_port: assert property (p_off_port)
		else $error("disabled port powered");

	c_pol_high: cover property ($rose(resetn_i) && pl);
	c_mtt: cover property (settled && multi_tt_o);
	c_one_port: cover property (settled && port_enabled_o == 4'h1);
endmodule // hslc_strap_led_sva

bind hslc_strap_led hslc_strap_led_sva hslc_strap_led_sva_i (.*);

// [bench/hslc_board_model.sv]
// Board model: strap resistors and LEDs on the shared pins
`timescale 1ns/10ps
module hslc_board_model (
	input  logic [7:0] strap_i,
	input  logic [7:0] drv_i,
	input  logic [7:0] drv_oe_i,
	output logic [7:0] pin_o,
	output logic       pol_o
);
	// Strap order {pol,gang,mtt,led,dis,fix}; unstrapped amber 3 pulls up
	wire [7:0] pull = {strap_i[4], 1'b1, strap_i[5], strap_i[6], strap_i[3:0]};

	// Resistors set the level only while the block's drivers are off
	assign pin_o = (drv_oe_i & drv_i) | (~drv_oe_i & pull);
	assign pol_o = strap_i[7];
endmodule // hslc_board_model

// [bench/hslc_strap_led_bench.sv]
// Self-checking bench for the strap sampling and LED polarity block
`timescale 1ns/10ps
`include "hslc_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module hslc_strap_led_bench;
	logic        sys_clk_i, resetn_i, s_axi_awvalid_i, s_axi_awready_o;
	logic        s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
	logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
	logic        s_axi_rvalid_o, s_axi_rready_i, power_polarity_strap_i;
	logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_d;
	logic [3:0]  s_axi_wstrb_i, port_power_enable_o, port_enabled_o, pr;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rd_r;
	logic [1:0]  green_led_low_ports_i, green_led_low_ports_o;
	logic [1:0]  green_led_high_ports_i, green_led_high_ports_o;
	logic        green_led_low_ports_oe_o, green_led_high_ports_oe_o;
	logic        amber_led_port4_i, amber_led_port4_o, amber_led_port4_oe_o;
	logic        amber_led_port3_o, amber_led_port3_oe_o, multi_tt_o;
	logic        amber_led_port2_i, amber_led_port2_o, amber_led_port2_oe_o;
	logic        amber_led_port1_i, amber_led_port1_o, amber_led_port1_oe_o;
	logic        gang_power_o;
	logic [2:0]  non_removable_o;
	logic [7:0]  strap, pin, lr, s;
	int          n_fail, n_compared;
	wire  [7:0]  led_o = {amber_led_port4_o, amber_led_port3_o,
		amber_led_port2_o, amber_led_port1_o, green_led_high_ports_o,
		green_led_low_ports_o};
	wire  [7:0]  led_oe = {amber_led_port4_oe_o, amber_led_port3_oe_o,
		amber_led_port2_oe_o, amber_led_port1_oe_o,
		{2{green_led_high_ports_oe_o}}, {2{green_led_low_ports_oe_o}}};

	hslc_strap_led hslc_strap_led_i (.*);
	hslc_board_model hslc_board_model_i (.strap_i(strap), .drv_i(led_o),
		.drv_oe_i(led_oe), .pin_o(pin), .pol_o(power_polarity_strap_i));
	// Shared pins fed back into the strap inputs
	assign {amber_led_port4_i, amber_led_port2_i} = {pin[7], pin[5]};
	assign amber_led_port1_i = pin[4];
	assign green_led_high_ports_i = pin[3:2];
	assign green_led_low_ports_i = pin[1:0];

	// ========================================
	// Clock and expectations
	always #2 sys_clk_i = ~sys_clk_i;

	function automatic [7:0] exp_led(input [7:0] t, input [1:0] c);
		if (c[0])
			exp_led = ~(lr & {8{c[1]}});
		else
			exp_led = {~(t[4] & lr[7]), ~lr[6], t[5] ^ lr[5], t[6] ^ lr[4],
				t[3:0] ^ lr[3:0]};
	endfunction
	function automatic [2:0] exp_nrem(input [7:0] t);
		exp_nrem = 3'h7 >> (2'd3 - t[1:0]);
	endfunction

	// ========================================
	// Bus tasks and checks
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input [11:0] a, input [31:0] d);
		int n;
		@(posedge sys_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
			if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1 && n < 20);
		rd_r = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
		if (n >= 20) begin
			n_fail++;
			give_verdict();
		end
	endtask
	task automatic rd(input [11:0] a);
		int n;
		@(posedge sys_clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
			if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1 && n < 20);
		{rd_r, rd_d} = {s_axi_rresp_o, s_axi_rdata_o};
		s_axi_rready_i <= 1'b0;
		if (n >= 20) begin
			n_fail++;
			give_verdict();
		end
	endtask
	// Power level follows the polarity pin during reset, either way
	task automatic do_reset();
		@(posedge sys_clk_i);
		resetn_i <= 1'b0;
		strap <= s ^ 8'h80;
		repeat (6) @(posedge sys_clk_i);
		`CHK(port_power_enable_o, {4{s[7]}})
		strap <= s;
		repeat (14) @(posedge sys_clk_i);
		`CHK(port_power_enable_o, {4{~s[7]}})
		`CHK(led_oe, 8'h40)
		resetn_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
	endtask
	task automatic check_pins(input [1:0] c);
		logic [3:0] pe;
		pe = c[0] ? 4'hf : 4'hf >> s[3:2];
		`CHK(led_o, exp_led(s, c))
		`CHK(led_oe, 8'hff)
		`CHK(port_enabled_o, pe)
		`CHK(port_power_enable_o, (pr & pe) ^ {4{~s[7]}})
		`CHK({non_removable_o, multi_tt_o, gang_power_o},
			c[0] ? 5'h0 : {exp_nrem(s), s[5], s[6]})
	endtask

	// ========================================
	// Main sequence: eight strap codes with random polarity, random LED and power requests
	initial begin
		{sys_clk_i, resetn_i, s_axi_awvalid_i, s_axi_wvalid_i} = 4'h0;
		{s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 3'h0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 56'h0;
		s_axi_wstrb_i = 4'hf;
		{strap, n_fail, n_compared} = 72'h0;
		rd_d = $urandom(32'hf3c9_a807);
		for (int i = 0; i < 8; i++) begin
			s = {1'($urandom), i[2:0], i[2:1], i[1:0]};
			lr = 8'($urandom);
			pr = 4'($urandom);
			do_reset();
			for (int a = 0; a < 3; a++) begin
				rd(12'(a * 4));
				`CHK({rd_r, rd_d}, 34'h0)
			end
			rd(`HSLC_STAT_ADDR);
			`CHK(rd_d[15:0], {exp_nrem(s), 4'hf >> s[3:2], 1'b1, s})
			wr(`HSLC_LED_ADDR, {24'h0, lr});
			// Lane 0 not strobed: the LED byte must survive this write
			s_axi_wstrb_i <= 4'he;
			wr(`HSLC_LED_ADDR, {24'hff_ffff, ~lr});
			s_axi_wstrb_i <= 4'hf;
			wr(`HSLC_PWR_ADDR, {28'h0, pr});
			rd(`HSLC_LED_ADDR);
			`CHK(rd_d, {24'h0, lr})
			strap <= ~s;
			repeat (4) @(posedge sys_clk_i);
			rd(`HSLC_STAT_ADDR);
			`CHK(rd_d[15:0], {exp_nrem(s), 4'hf >> s[3:2], 1'b1, s})
			for (int c = 4; c < 8; c++) begin
				wr(`HSLC_CTRL_ADDR, 32'(c & 3));
				repeat (3) @(posedge sys_clk_i);
				check_pins(2'(c & 3));
			end
			wr(`HSLC_STAT_ADDR, 32'hffff_ffff);
			`CHK(rd_r, `HSLC_RESP_SLVERR)
			rd(12'h010);
			`CHK({rd_r, rd_d}, {`HSLC_RESP_SLVERR, 32'h0})
			$display("test %0d done", i);
		end
		give_verdict();
	end
endmodule // hslc_strap_led_bench
